/* core/epe_control.sv */
// Program/erase control for one EEPROM array, with its registers on AXI4-Lite.
// Assumes one clock, synchronous stop input, and one instance per array.
`timescale 1ns/100ps
`default_nettype none
`include "epe_map.svh"

module epe_control (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  stop_mode,
  input  wire logic [`EPE_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`EPE_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       pump_clock_select,
  output logic                       array_power_down,
  output logic                       charge_pump_on,
  output logic [1:0]                 mcu_config_bits
);

  epe_pkg::epe_ctrl_t  ctrl_reg,   ctrl_next;
  epe_pkg::epe_cfg_t   nv_reg,     nv_next;
  epe_pkg::epe_cfg_t   shadow_reg, shadow_next;
  epe_pkg::epe_latch_t lat_reg,    lat_next;
  logic                shadow_load_reg, shadow_load_next;
  logic                pump_on_reg, pump_on_next;
  logic                bvalid_reg, bvalid_next;
  logic [1:0]          bresp_reg, bresp_next;
  logic                rvalid_reg, rvalid_next;
  logic [1:0]          rresp_reg, rresp_next;
  logic [31:0]         rdata_reg, rdata_next;

  logic                       wr_go, rd_go;
  logic                       w_ctrl, w_nv, w_shadow, w_status, w_array;
  logic                       r_ctrl, r_nv, r_shadow, r_status, r_array;
  logic [`EPE_IDX_W-1:0]      w_idx, r_idx;
  logic                       lock, w_secure, lat_secure, lat_blk_prot, target_prot;
  logic [7:0]                 arr_rd_data;
  epe_pkg::epe_ctrl_t         wctrl;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes: a write is taken only with address and data both present
  assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = ce && s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Address decode
  always_comb begin
    w_ctrl = 1'b0; w_nv = 1'b0; w_shadow = 1'b0; w_status = 1'b0; w_array = 1'b0;
    if (s_axi_awaddr == `EPE_OFF_CTRL) w_ctrl = 1'b1;
    else if (s_axi_awaddr == `EPE_OFF_NVCFG) w_nv = 1'b1;
    else if (s_axi_awaddr == `EPE_OFF_SHADOW) w_shadow = 1'b1;
    else if (s_axi_awaddr == `EPE_OFF_STATUS) w_status = 1'b1;
    else if ((s_axi_awaddr & `EPE_ARRAY_MASK) == `EPE_ARRAY_BASE) w_array = 1'b1;
  end

  always_comb begin
    r_ctrl = 1'b0; r_nv = 1'b0; r_shadow = 1'b0; r_status = 1'b0; r_array = 1'b0;
    if (s_axi_araddr == `EPE_OFF_CTRL) r_ctrl = 1'b1;
    else if (s_axi_araddr == `EPE_OFF_NVCFG) r_nv = 1'b1;
    else if (s_axi_araddr == `EPE_OFF_SHADOW) r_shadow = 1'b1;
    else if (s_axi_araddr == `EPE_OFF_STATUS) r_status = 1'b1;
    else if ((s_axi_araddr & `EPE_ARRAY_MASK) == `EPE_ARRAY_BASE) r_array = 1'b1;
  end

  assign w_idx = s_axi_awaddr[`EPE_IDX_MSB:`EPE_IDX_LSB];
  assign r_idx = s_axi_araddr[`EPE_IDX_MSB:`EPE_IDX_LSB];
  assign wctrl = epe_pkg::epe_ctrl_t'(s_axi_wdata[7:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // Protection seen by the current latched target
  assign lock     = !shadow_reg.secure_region_lock;
  assign w_secure = lock && (w_idx >= `EPE_SECURE_LO) && (w_idx <= `EPE_SECURE_HI);
  // A target latched before the lock took effect must still be refused
  assign lat_secure = lock && (lat_reg.idx >= `EPE_SECURE_LO) && (lat_reg.idx <= `EPE_SECURE_HI);
  assign lat_blk_prot = shadow_reg.block_protect[lat_reg.idx[`EPE_BLK_MSB:`EPE_BLK_LSB]];

  always_comb begin
    target_prot = lat_blk_prot || lat_secure;
    if (lat_reg.nv) begin
      target_prot = lock || ctrl_reg.erase_mode == epe_pkg::EPE_BLOCK_ERASE
                         || ctrl_reg.erase_mode == epe_pkg::EPE_BULK_ERASE;
    end else if (ctrl_reg.erase_mode == epe_pkg::EPE_BULK_ERASE) begin
      target_prot = lock || (shadow_reg.block_protect != 4'h0);
    end else if (ctrl_reg.erase_mode == epe_pkg::EPE_BLOCK_ERASE) begin
      target_prot = lock || lat_blk_prot;
    end
  end

  // Stop cuts the pump without touching the enable bit; wait mode has no say here
  always_comb begin
    pump_on_next = ctrl_reg.high_voltage_enable && ctrl_reg.bus_latch_enable && lat_reg.valid
                   && !target_prot && !stop_mode && !ctrl_reg.array_power_down;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register, latch and nonvolatile byte
  always_comb begin
    ctrl_next = ctrl_reg;
    lat_next  = lat_reg;
    nv_next   = nv_reg;
    if (wr_go && s_axi_wstrb[0]) begin
      if (w_ctrl && !(ctrl_reg.bus_latch_enable && !lat_reg.valid)) begin
        ctrl_next.pump_clock_select = wctrl.pump_clock_select;
        ctrl_next.array_power_down  = wctrl.array_power_down;
        if (!ctrl_reg.high_voltage_enable) begin
          ctrl_next.erase_mode = wctrl.erase_mode;
        end
        ctrl_next.bus_latch_enable = wctrl.bus_latch_enable || ctrl_reg.high_voltage_enable;
        ctrl_next.high_voltage_enable = wctrl.high_voltage_enable && ctrl_reg.bus_latch_enable
                                        && lat_reg.valid;
        if (!ctrl_reg.bus_latch_enable) begin
          lat_next.valid = 1'b0;
        end
      end else if (ctrl_reg.bus_latch_enable && !ctrl_reg.high_voltage_enable) begin
        if (w_array && !w_secure) begin
          lat_next.idx   = w_idx;
          lat_next.data  = s_axi_wdata[7:0];
          lat_next.nv    = 1'b0;
          lat_next.valid = 1'b1;
        end else if (w_nv && !lock) begin
          lat_next.data  = s_axi_wdata[7:0];
          lat_next.nv    = 1'b1;
          lat_next.valid = 1'b1;
        end
      end
    end
    // Config byte changes only through the latched high-voltage path
    if (pump_on_next && lat_reg.nv) begin
      if (ctrl_reg.erase_mode == epe_pkg::EPE_BYTE_PROG) begin
        nv_next = nv_reg & lat_reg.data;
      end else begin
        nv_next = `EPE_ERASED;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= `EPE_CTRL_RST;
      lat_reg     <= '0;
      nv_reg      <= `EPE_NV_SHIP;
      pump_on_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg    <= ctrl_next;
      lat_reg     <= lat_next;
      nv_reg      <= nv_next;
      pump_on_reg <= pump_on_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow: loaded in the first enabled cycle after reset, then on each config byte read
  always_comb begin
    shadow_next      = shadow_reg;
    shadow_load_next = 1'b0;
    if (shadow_load_reg || (rd_go && r_nv)) begin
      shadow_next = nv_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg      <= '0;
      shadow_load_reg <= 1'b1;
    end else if (ce) begin
      shadow_reg      <= shadow_next;
      shadow_load_reg <= shadow_load_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Responses: one cycle after the request is taken
  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    if (wr_go) begin
      bvalid_next = 1'b1;
      bresp_next  = (w_ctrl || w_nv || w_shadow || w_status || w_array) ? `EPE_RESP_OKAY : `EPE_RESP_SLVERR;
    end
    if (rd_go) begin
      rvalid_next = 1'b1;
      rresp_next  = `EPE_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (r_ctrl) rdata_next[7:0] = ctrl_reg;
      else if (r_nv) rdata_next[7:0] = nv_reg;
      else if (r_shadow) rdata_next[7:0] = shadow_reg;
      else if (r_status) rdata_next[1:0] = {lat_reg.valid, pump_on_reg};
      else if (r_array) begin
        // Powered-down array reads as zero rather than garbage
        if (ctrl_reg.array_power_down) rdata_next[7:0] = 8'h00;
        else if (ctrl_reg.bus_latch_enable && lat_reg.valid) rdata_next[7:0] = lat_reg.data;
        else rdata_next[7:0] = arr_rd_data;
      end else rresp_next = `EPE_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `EPE_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `EPE_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array cells
  epe_array_store u_store (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .op_en   (pump_on_next && !lat_reg.nv),
    .op_mode (ctrl_reg.erase_mode),
    .op_idx  (lat_reg.idx),
    .op_data (lat_reg.data),
    .rd_idx  (r_idx),
    .rd_data (arr_rd_data)
  );

  assign pump_clock_select = ctrl_reg.pump_clock_select;
  assign array_power_down  = ctrl_reg.array_power_down;
  assign charge_pump_on    = pump_on_reg;
  assign mcu_config_bits   = shadow_reg.mcu_config_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_latch_held;
    (ce && ctrl_reg.high_voltage_enable) |=> ctrl_reg.bus_latch_enable;
  endproperty
  a_latch_held: assert property (p_latch_held) else $error("latch cleared under high voltage");

  property p_hv_qualified;
    ctrl_reg.high_voltage_enable |-> ctrl_reg.bus_latch_enable && lat_reg.valid;
  endproperty
  a_hv_qualified: assert property (p_hv_qualified) else $error("high voltage without latched write");

  property p_stop_cuts;
    (ce && stop_mode) |=> !charge_pump_on;
  endproperty
  a_stop_cuts: assert property (p_stop_cuts) else $error("pump on during stop");

  property p_pump_cause;
    charge_pump_on |-> $past(ctrl_reg.high_voltage_enable);
  endproperty
  a_pump_cause: assert property (p_pump_cause) else $error("pump on without enable");

  property p_mode_frozen;
    (ce && ctrl_reg.high_voltage_enable) |=> $stable(ctrl_reg.erase_mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed under high voltage");

  property p_off_read;
    (rd_go && r_array && ctrl_reg.array_power_down) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_off_read: assert property (p_off_read) else $error("powered-down read not zero");

  property p_reload;
    (rd_go && r_nv) |=> shadow_reg == $past(nv_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("shadow not reloaded");

  property p_boot_load;
    $fell(shadow_load_reg) |-> shadow_reg == $past(nv_reg);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("shadow not loaded after reset");

  property p_lock_modes;
    (pump_on_next && lock) |-> !lat_reg.nv
                               && ctrl_reg.erase_mode inside {epe_pkg::EPE_BYTE_PROG, epe_pkg::EPE_BYTE_ERASE};
  endproperty
  a_lock_modes: assert property (p_lock_modes) else $error("locked part erased block or config");

  property p_block_guard;
    (pump_on_next && !lat_reg.nv) |-> !lat_blk_prot;
  endproperty
  a_block_guard: assert property (p_block_guard) else $error("protected block programmed");

  property p_secure_guard;
    (pump_on_next && !lat_reg.nv && lock) |-> !(lat_reg.idx inside {[`EPE_SECURE_LO:`EPE_SECURE_HI]});
  endproperty
  a_secure_guard: assert property (p_secure_guard) else $error("locked secure byte changed");

endmodule : epe_control

`default_nettype wire

/* core/epe_map.svh */
// Address map, field values and reset values of the EEPROM program/erase control block.
// Assumes the includer already has the package of the block compiled.
`ifndef EPE_MAP_SVH
`define EPE_MAP_SVH

`define EPE_ADDR_W       13
`define EPE_OFF_CTRL     13'h000
`define EPE_OFF_NVCFG    13'h004
`define EPE_OFF_SHADOW   13'h008
`define EPE_OFF_STATUS   13'h00c
`define EPE_ARRAY_BASE   13'h1000
`define EPE_ARRAY_MASK   13'h1803
`define EPE_IDX_MSB      10
`define EPE_IDX_LSB      2
`define EPE_IDX_W        9
`define EPE_DEPTH        512
`define EPE_BLK_MSB      8
`define EPE_BLK_LSB      7
`define EPE_SECURE_LO    9'h0f0
`define EPE_SECURE_HI    9'h0ff
`define EPE_ERASED       8'hff
`define EPE_NV_SHIP      8'h10
`define EPE_CTRL_RST     8'h00
`define EPE_RESP_OKAY    2'h0
`define EPE_RESP_SLVERR  2'h2

`endif

/* core/epe_pkg.sv */
// Types shared by the EEPROM program/erase control block.
// Assumes nothing of its surroundings.
package epe_pkg;

  typedef enum logic [1:0] {
    EPE_BYTE_PROG,
    EPE_BYTE_ERASE,
    EPE_BLOCK_ERASE,
    EPE_BULK_ERASE
  } epe_mode_t;

  typedef struct packed {
    logic      pump_clock_select;
    logic      rsv6;
    logic      array_power_down;
    epe_mode_t erase_mode;
    logic      bus_latch_enable;
    logic      rsv1;
    logic      high_voltage_enable;
  } epe_ctrl_t;

  typedef struct packed {
    logic       redundant_array_reserved;
    logic [1:0] mcu_config_bits;
    logic       secure_region_lock;
    logic [3:0] block_protect;
  } epe_cfg_t;

  typedef struct packed {
    logic [8:0] idx;
    logic [7:0] data;
    logic       nv;
    logic       valid;
  } epe_latch_t;

endpackage : epe_pkg

/* core/epe_array_store.sv */
// Flip-flop model of one 512-byte array, with program and erase applied while enabled.
// Assumes the caller has already checked protection and the high-voltage interlock.
`timescale 1ns/100ps
`default_nettype none
`include "epe_map.svh"

module epe_array_store (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   op_en,
  input  wire epe_pkg::epe_mode_t     op_mode,
  input  wire logic [`EPE_IDX_W-1:0]  op_idx,
  input  wire logic [7:0]             op_data,
  input  wire logic [`EPE_IDX_W-1:0]  rd_idx,
  output logic      [7:0]             rd_data
);

  logic [7:0] mem_view [`EPE_DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // No pulse timer: the cell follows the operation while enabled, so length is software's
  genvar g;
  generate
    for (g = 0; g < `EPE_DEPTH; g++) begin : g_cell
      localparam logic [`EPE_IDX_W-1:0] CELL = `EPE_IDX_W'(g);
      logic [7:0] cell_reg;
      logic [7:0] cell_next;
      always_comb begin
        cell_next = cell_reg;
        if (op_en) begin
          case (op_mode)
            epe_pkg::EPE_BYTE_PROG: begin
              if (op_idx == CELL) cell_next = cell_reg & op_data;
            end
            epe_pkg::EPE_BYTE_ERASE: begin
              if (op_idx == CELL) cell_next = `EPE_ERASED;
            end
            epe_pkg::EPE_BLOCK_ERASE: begin
              if (op_idx[`EPE_BLK_MSB:`EPE_BLK_LSB] == CELL[`EPE_BLK_MSB:`EPE_BLK_LSB]) begin
                cell_next = `EPE_ERASED;
              end
            end
            epe_pkg::EPE_BULK_ERASE: begin
              cell_next = `EPE_ERASED;
            end
          endcase
        end
      end
      // Reset stands in for the shipped, fully erased state
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cell_reg <= `EPE_ERASED;
        end else if (ce) begin
          cell_reg <= cell_next;
        end
      end
      assign mem_view[g] = cell_reg;
    end
  endgenerate

  assign rd_data = mem_view[rd_idx];

endmodule : epe_array_store

`default_nettype wire

/* tb/epe_cpu_model.sv */
// Software side of the block: an AXI4-Lite master issuing single register and array accesses.
// Assumes the slave answers on its own; every wait is bounded and raises hung when it runs out.
`timescale 1ns/100ps
`default_nettype none

module epe_cpu_model (
  input  wire logic        clk,
  output logic [12:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [12:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             hung
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data bytes carry redundant_array_reserved as 0 where they reach it
  task automatic wr(input logic [12:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hung <= 1'b1;
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    {d, r} = '1;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hung <= 1'b1;
  endtask : rd
endmodule : epe_cpu_model

`default_nettype wire

/* tb/epe_control_test.sv */
// Self-checking bench: register, latch, program, erase, protection and stop sequences.
// Assumes the bus model answers single accesses; pulse length is set by holding hv.
`timescale 1ns/100ps
`default_nettype none
`include "epe_map.svh"

module epe_control_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        stop_mode = 1'b0;
  logic [12:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mcu_config_bits;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, hung;
  logic        arvalid, arready, rvalid, rready;
  logic        pump_clock_select, array_power_down, charge_pump_on;
  logic        ce = 1'b1;
  int          failures = 0;
  int          checks = 0;

  always #20 clk = ~clk;

  epe_control uut (.clk(clk), .rst_n(rst_n), .ce(ce), .stop_mode(stop_mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pump_clock_select(pump_clock_select), .array_power_down(array_power_down),
    .charge_pump_on(charge_pump_on), .mcu_config_bits(mcu_config_bits));

  epe_cpu_model cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hung(hung));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge hung) begin
    failures++;
    complete_run();
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [12:0] af(input logic [8:0] i);
    return `EPE_ARRAY_BASE | {2'b00, i, 2'b00};
  endfunction : af

  task automatic w(input logic [12:0] a, input logic [7:0] d);
    logic [1:0] r;
    cpu.wr(a, d, r);
    check("bresp", r, `EPE_RESP_OKAY);
  endtask : w

  task automatic rc(input logic [12:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.rd(a, d, r);
    check("rresp", r, `EPE_RESP_OKAY);
    check("rdata", d, {24'h000000, exp});
  endtask : rc

  // Full sequence: mode and latch, target write, pulse, hv off first, then latch off
  task automatic op(input logic [1:0] mode, input logic [12:0] a, input logic [7:0] d);
    w(`EPE_OFF_CTRL, {3'b000, mode, 3'b100});
    w(a, d);
    w(`EPE_OFF_CTRL, {3'b000, mode, 3'b101});
    repeat (4) @(posedge clk);
    w(`EPE_OFF_CTRL, {3'b000, mode, 3'b100});
    w(`EPE_OFF_CTRL, 8'h00);
  endtask : op

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(`EPE_OFF_CTRL, `EPE_CTRL_RST);
    check("pump_clock_select", pump_clock_select, 0);
    check("mcu_config_bits", mcu_config_bits, 0);
    rc(`EPE_OFF_SHADOW, `EPE_NV_SHIP);
    rc(`EPE_OFF_NVCFG, `EPE_NV_SHIP);
    rc(af(9'h003), `EPE_ERASED);
    cpu.rd(13'h0010, d, r);
    check("unmapped rresp", r, `EPE_RESP_SLVERR);
    check("unmapped rdata", d, 0);
    cpu.wr(13'h0010, 8'h00, r);
    check("unmapped bresp", r, `EPE_RESP_SLVERR);
    w(`EPE_OFF_CTRL, 8'ha0);                          // bus clock pump is fine at 25 MHz
    check("pump_clock_select", pump_clock_select, 1);
    check("array_power_down", array_power_down, 1);
    rc(af(9'h003), 8'h00);
    w(`EPE_OFF_CTRL, 8'h00);
    repeat (4) @(posedge clk);                        // recovery before array access
    w(`EPE_OFF_CTRL, 8'h01);
    rc(`EPE_OFF_CTRL, 8'h00);
    w(`EPE_OFF_CTRL, 8'h04);
    w(af(9'h005), 8'h5a);
    rc(af(9'h009), 8'h5a);
    w(`EPE_OFF_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    check("charge_pump_on", charge_pump_on, 1);
    rc(`EPE_OFF_STATUS, 8'h03);
    ce <= 1'b0;
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    check("frozen charge_pump_on", charge_pump_on, 1);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check("charge_pump_on", charge_pump_on, 0);
    rc(`EPE_OFF_CTRL, 8'h05);
    stop_mode <= 1'b0;
    repeat (2) @(posedge clk);                        // pulse stretched and recovery kept
    check("charge_pump_on", charge_pump_on, 1);
    w(`EPE_OFF_CTRL, 8'h18);
    rc(`EPE_OFF_CTRL, 8'h04);
    w(`EPE_OFF_CTRL, 8'h00);
    rc(af(9'h005), 8'h5a);
    op(2'h0, af(9'h085), 8'h33);
    op(2'h2, af(9'h080), 8'h00);
    rc(af(9'h085), `EPE_ERASED);
    rc(af(9'h005), 8'h5a);
    op(2'h1, af(9'h005), 8'h00);
    rc(af(9'h005), `EPE_ERASED);
    op(2'h0, af(9'h100), 8'h00);
    op(2'h3, af(9'h1ff), 8'h00);
    rc(af(9'h100), `EPE_ERASED);
    op(2'h1, `EPE_OFF_NVCFG, 8'h00);
    op(2'h0, `EPE_OFF_NVCFG, 8'h71);
    rc(`EPE_OFF_SHADOW, `EPE_NV_SHIP);
    rc(`EPE_OFF_NVCFG, 8'h71);
    rc(`EPE_OFF_SHADOW, 8'h71);
    check("mcu_config_bits", mcu_config_bits, 3);
    w(`EPE_OFF_SHADOW, 8'h00);
    rc(`EPE_OFF_SHADOW, 8'h71);
    op(2'h0, af(9'h005), 8'h00);
    rc(af(9'h005), `EPE_ERASED);
    op(2'h0, af(9'h085), 8'h0f);
    rc(af(9'h085), 8'h0f);
    op(2'h0, `EPE_OFF_NVCFG, 8'h61);
    rc(`EPE_OFF_NVCFG, 8'h61);
    op(2'h2, af(9'h085), 8'h00);
    rc(af(9'h085), 8'h0f);
    op(2'h1, af(9'h085), 8'h00);
    rc(af(9'h085), `EPE_ERASED);
    // A locked secure write is not a valid write, so the latch cannot be released afterwards
    w(`EPE_OFF_CTRL, 8'h04);
    w(af(9'h0f5), 8'h00);
    w(`EPE_OFF_CTRL, 8'h05);
    rc(`EPE_OFF_CTRL, 8'h04);
    rc(af(9'h0f5), `EPE_ERASED);
    complete_run();
  end
endmodule : epe_control_test

`default_nettype wire
